// ### rtl/tlic_pkg.sv
// Purpose : shared constants and types for the two-level interrupt controller
// Assumes : apb with 32-bit data, registers one aligned word each
// Notes   : enable and priority register offsets are byte addresses scaled from their indices; the others are fixed addresses
`default_nettype none
package tlic_pkg;
    localparam int          TLIC_NSRC       = 11;
    localparam int          TLIC_AW         = 12;
    // register indices and byte addresses
    localparam logic [7:0]  TLIC_IDX_ENP    = 8'hA8;
    localparam logic [7:0]  TLIC_IDX_ENS    = 8'hA9;
    localparam logic [7:0]  TLIC_IDX_PRP    = 8'hB8;
    localparam logic [11:0] TLIC_ADR_ENP    = {2'h0, TLIC_IDX_ENP, 2'h0};
    localparam logic [11:0] TLIC_ADR_ENS    = {2'h0, TLIC_IDX_ENS, 2'h0};
    localparam logic [11:0] TLIC_ADR_PRP    = {2'h0, TLIC_IDX_PRP, 2'h0};
    localparam logic [11:0] TLIC_ADR_ACK    = 12'h300;
    localparam logic [11:0] TLIC_ADR_RETI   = 12'h304;
    localparam logic [11:0] TLIC_ADR_STAT   = 12'h308;
    localparam logic [11:0] TLIC_ADR_IRQST  = 12'h30C;
    localparam logic [11:0] TLIC_ADR_IRQEN  = 12'h310;
    localparam logic [11:0] TLIC_ADR_IRQCLR = 12'h314;
    // reset values
    localparam logic [7:0]  TLIC_RST_ENP    = 8'h00;
    localparam logic [7:0]  TLIC_RST_ENS    = 8'hA0;
    localparam logic [7:0]  TLIC_RST_PRP    = 8'h00;
    // field positions
    localparam int          TLIC_GATE_BIT   = 7;
    localparam int          TLIC_ENS_MBZ    = 3;
    localparam logic [7:0]  TLIC_PRP_MASK   = 8'h7F;
    localparam logic [7:0]  TLIC_ENS_MASK   = 8'hF7;
    // source indices in polling order, 0 wins
    localparam int          S_SUPPLY = 0, S_WDOG = 1, S_EXT0 = 2, S_CONV = 3, S_TMR0 = 4, S_EXT1 = 5;
    localparam int          S_TMR1 = 6, S_SERIF = 7, S_UART = 8, S_TMR2 = 9, S_INTV = 10;
    typedef logic [15:0] tlic_vec_t;
    localparam tlic_vec_t   TLIC_VEC [TLIC_NSRC] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
                                                     16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B,
                                                     16'h0053};
    typedef enum logic [1:0] {TLIC_IDLE, TLIC_LOW, TLIC_HIGH, TLIC_BOTH} tlic_lvl_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] src;
        tlic_vec_t  vector;
    } tlic_vreq_t;
endpackage : tlic_pkg
`default_nettype wire

// ### rtl/tlic_ctrl.sv
// Purpose : two-level interrupt controller with apb register access
// Assumes : requests are synchronous levels on pclk; core acks a vector and reports return
// Notes   : the core pushes its pc and jumps to vreq.vector when it writes the ack register
//
// How it works
// - Two priority levels are set up through three software registers.
// - Bit 7 of the primary enable register gates every source off when low.
// - Primary enable bits 6..0 enable converter, timer2, uart, timer1, ext1, timer0, ext0.
// - Primary priority bits 6..0 select high level for the same sources, bit 7 reserved.
// - Secondary bits 2..0 enable interval, supply monitor and serial interface sources.
// - Secondary bits 6..4 set the level of interval, supply monitor and serial interface.
// - A pending enabled high request preempts a low service routine.
// - With both levels pending the high one is vectored first.
// - A routine is never preempted by a request of its own level.
// - Same-level requests are polled in a fixed order, supply monitor first, interval last.
// - On acceptance the core pushes its pc and loads the chosen vector.
// - Each source has its fixed vector address.
//
// The APB register port was decided locally.
`default_nettype none
module tlic_ctrl
    import tlic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_mon_request,
    input  wire logic        watchdog_request,
    input  wire logic        ext0_request,
    input  wire logic        converter_request,
    input  wire logic        timer0_overflow,
    input  wire logic        ext1_request,
    input  wire logic        timer1_overflow,
    input  wire logic        serial_if_request,
    input  wire logic        serial_rx_done,
    input  wire logic        serial_tx_done,
    input  wire logic        timer2_overflow,
    input  wire logic        timer2_external_flag,
    input  wire logic        interval_request,
    output tlic_vreq_t       vreq,
    output logic             irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]           enp_q, ens_q, prp_q;
    tlic_lvl_t            lvl_q;
    logic [TLIC_NSRC-1:0] raw, en, hi, pend;
    logic [3:0]           evst_q, evmask_q;
    tlic_vreq_t           vreq_d;
    logic                 wr, rd, hit;
    logic                 ack_wr, reti_wr;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !penable && !pwrite;
    assign ack_wr  = wr && (paddr == TLIC_ADR_ACK);
    assign reti_wr = wr && (paddr == TLIC_ADR_RETI);

    // unmapped addresses answer with an error rather than stalling the bus
    always_comb begin
        hit = (paddr == TLIC_ADR_ENP) || (paddr == TLIC_ADR_ENS) || (paddr == TLIC_ADR_PRP) ||
              (paddr == TLIC_ADR_ACK) || (paddr == TLIC_ADR_RETI) || (paddr == TLIC_ADR_STAT) ||
              (paddr == TLIC_ADR_IRQST) || (paddr == TLIC_ADR_IRQEN) || (paddr == TLIC_ADR_IRQCLR);
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enp_q <= TLIC_RST_ENP;
            ens_q <= TLIC_RST_ENS;
            prp_q <= TLIC_RST_PRP;
        end else if (wr) begin
            if (paddr == TLIC_ADR_ENP) begin
                enp_q <= pwdata[7:0];
            end
            // bit 3 forced low so a careless write cannot set it
            if (paddr == TLIC_ADR_ENS) begin
                ens_q <= pwdata[7:0] & TLIC_ENS_MASK;
            end
            if (paddr == TLIC_ADR_PRP) begin
                prp_q <= pwdata[7:0] & TLIC_PRP_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // request collection, enables and levels
    // ------------------------------------------------------------
    always_comb begin
        raw = '0;
        raw[S_SUPPLY] = supply_mon_request;
        raw[S_WDOG]   = watchdog_request;
        raw[S_EXT0]   = ext0_request;
        raw[S_CONV]   = converter_request;
        raw[S_TMR0]   = timer0_overflow;
        raw[S_EXT1]   = ext1_request;
        raw[S_TMR1]   = timer1_overflow;
        raw[S_SERIF]  = serial_if_request;
        raw[S_UART]   = serial_rx_done | serial_tx_done;
        raw[S_TMR2]   = timer2_overflow | timer2_external_flag;
        raw[S_INTV]   = interval_request;
        // watchdog has no enable bit of its own; only the global gate bit 7 masks it
        en = '0;
        en[S_WDOG]   = 1'b1;
        en[S_EXT0]   = enp_q[0];
        en[S_TMR0]   = enp_q[1];
        en[S_EXT1]   = enp_q[2];
        en[S_TMR1]   = enp_q[3];
        en[S_UART]   = enp_q[4];
        en[S_TMR2]   = enp_q[5];
        en[S_CONV]   = enp_q[6];
        en[S_SERIF]  = ens_q[0];
        en[S_SUPPLY] = ens_q[1];
        en[S_INTV]   = ens_q[2];
        hi = '0;
        hi[S_WDOG]   = 1'b1;
        hi[S_EXT0]   = prp_q[0];
        hi[S_TMR0]   = prp_q[1];
        hi[S_EXT1]   = prp_q[2];
        hi[S_TMR1]   = prp_q[3];
        hi[S_UART]   = prp_q[4];
        hi[S_TMR2]   = prp_q[5];
        hi[S_CONV]   = prp_q[6];
        hi[S_SERIF]  = ens_q[4];
        hi[S_SUPPLY] = ens_q[5];
        hi[S_INTV]   = ens_q[6];
        pend = raw & en & {TLIC_NSRC{enp_q[TLIC_GATE_BIT]}};
    end

    // ------------------------------------------------------------
    // arbitration: level first, then polling order
    // ------------------------------------------------------------
    always_comb begin
        logic [TLIC_NSRC-1:0] cand;
        cand   = '0;
        vreq_d = '0;
        case (lvl_q)
            TLIC_IDLE: cand = (|(pend & hi)) ? (pend & hi) : pend;
            TLIC_LOW:  cand = pend & hi;
            TLIC_HIGH: cand = '0;
            TLIC_BOTH: cand = '0;
            default:   cand = '0;
        endcase
        // walk from the bottom so the lowest index, first in the poll, is written last
        for (int i = TLIC_NSRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                vreq_d.valid  = 1'b1;
                vreq_d.src    = 4'(i);
                vreq_d.vector = TLIC_VEC[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vreq <= '0;
        end else begin
            // taking the offer clears it at once, so a held level is not taken twice
            vreq <= (ack_wr && vreq.valid) ? '0 : vreq_d;
        end
    end

    // ------------------------------------------------------------
    // in-service level tracking
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= TLIC_IDLE;
        end else if (ack_wr && vreq.valid) begin
            case (lvl_q)
                TLIC_IDLE: lvl_q <= hi[vreq.src] ? TLIC_HIGH : TLIC_LOW;
                // a preempted low routine is remembered under the high one
                TLIC_LOW:  lvl_q <= TLIC_BOTH;
                default:   lvl_q <= lvl_q;
            endcase
        end else if (reti_wr) begin
            case (lvl_q)
                TLIC_BOTH: lvl_q <= TLIC_LOW;
                default:   lvl_q <= TLIC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // event status, enable, clear and interrupt line
    // ------------------------------------------------------------
    logic [3:0] ev;
    // events: 0 vector accepted, 1 preemption, 2 return, 3 write to reserved bit
    assign ev = {wr && paddr == TLIC_ADR_ENS && pwdata[TLIC_ENS_MBZ],
                 reti_wr, ack_wr && vreq.valid && lvl_q == TLIC_LOW, ack_wr && vreq.valid};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evst_q <= 4'h0;
        end else begin
            // set wins over a clear in the same cycle
            evst_q <= (evst_q & ~((wr && paddr == TLIC_ADR_IRQCLR) ? pwdata[3:0] : 4'h0)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evmask_q <= 4'h0;
        end else if (wr && paddr == TLIC_ADR_IRQEN) begin
            evmask_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((evst_q & ~((wr && paddr == TLIC_ADR_IRQCLR) ? pwdata[3:0] : 4'h0)) | ev) & evmask_q);
        end
    end

    // ------------------------------------------------------------
    // apb read path and answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            case (paddr)
                TLIC_ADR_ENP:   prdata <= {24'h00_0000, enp_q};
                TLIC_ADR_ENS:   prdata <= {24'h00_0000, ens_q};
                TLIC_ADR_PRP:   prdata <= {24'h00_0000, prp_q};
                TLIC_ADR_STAT:  prdata <= {9'h000, vreq.vector, vreq.src, 1'b0, lvl_q};
                TLIC_ADR_IRQST: prdata <= {28'h000_0000, evst_q};
                TLIC_ADR_IRQEN: prdata <= {28'h000_0000, evmask_q};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // no wait states: every access is answered one cycle after its setup
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    // ------------------------------------------------------------
    // level map behind the offer
    // ------------------------------------------------------------
    // the offer is built from last cycle's levels; checks compare against this copy
    logic [TLIC_NSRC-1:0] hi_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= '0;
        end else begin
            hi_q <= hi;
        end
    end

    // ------------------------------------------------------------
    // checks: arbitration and service
    // ------------------------------------------------------------
    chk_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        !enp_q[TLIC_GATE_BIT] && !ack_wr |=> !vreq.valid)
        else $error("vector offered while global gate is off");
    chk_same_level: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_HIGH |=> !vreq.valid)
        else $error("request offered during high level routine");
    chk_low_preempt: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_LOW && vreq.valid |-> hi_q[vreq.src])
        else $error("low request offered during low routine");
    chk_high_first: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_IDLE && |(pend & hi) && !ack_wr |=> vreq.valid && hi_q[vreq.src])
        else $error("high request not vectored first");
    chk_vector_map: assert property (@(posedge pclk) disable iff (!presetn)
        vreq.valid |-> vreq.vector == TLIC_VEC[vreq.src])
        else $error("vector does not match source");
    chk_poll_order: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_IDLE && pend[S_SUPPLY] && hi[S_SUPPLY] && !ack_wr |=> vreq.src == 4'h0)
        else $error("supply monitor not first in polling");
    chk_mbz_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 !ens_q[TLIC_ENS_MBZ])
        else $error("reserved secondary bit set");
    chk_ack_level: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_IDLE && ack_wr && vreq.valid |=> lvl_q != TLIC_IDLE ##1 1'b1)
        else $error("accepted vector did not enter service");
    chk_shared_uart: assert property (@(posedge pclk) disable iff (!presetn)
        enp_q[TLIC_GATE_BIT] && en[S_UART] && lvl_q == TLIC_IDLE && !ack_wr && raw == (11'h001 << S_UART)
        |=> vreq.vector == 16'h0023)
        else $error("serial flags not sharing vector");
    chk_shared_timer2: assert property (@(posedge pclk) disable iff (!presetn)
        enp_q[TLIC_GATE_BIT] && en[S_TMR2] && lvl_q == TLIC_IDLE && !ack_wr && raw == (11'h001 << S_TMR2)
        |=> vreq.vector == 16'h002B)
        else $error("timer2 flags not sharing vector");
    chk_both_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_BOTH |=> !vreq.valid)
        else $error("request offered while both levels are in service");
    chk_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
        ack_wr && vreq.valid |=> !vreq.valid)
        else $error("taken vector still offered");
    chk_reti_unwind: assert property (@(posedge pclk) disable iff (!presetn)
        reti_wr && lvl_q == TLIC_BOTH |=> lvl_q == TLIC_LOW)
        else $error("return from high routine lost the low routine");
    chk_idle_offer: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == TLIC_IDLE && (|pend) && !ack_wr |=> vreq.valid)
        else $error("pending request not offered");
    chk_enable_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(raw & en)) |=> !vreq.valid)
        else $error("vector offered for a disabled source");

    // ------------------------------------------------------------
    // checks: bus, registers and events
    // ------------------------------------------------------------
    chk_prp_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == TLIC_ADR_PRP |=> (prp_q & ~TLIC_PRP_MASK) == 8'h00 && prp_q[6:0] == $past(pwdata[6:0]))
        else $error("priority register write not stored");
    chk_ens_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == TLIC_ADR_ENS |=> !ens_q[TLIC_ENS_MBZ] && ens_q[2:0] == $past(pwdata[2:0]) &&
        ens_q[6:4] == $past(pwdata[6:4]))
        else $error("secondary register write not stored");
    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (|ev) |=> (evst_q & $past(ev)) == $past(ev))
        else $error("event lost against a clear");
    chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == (|(evst_q & $past(evmask_q))))
        else $error("interrupt line does not follow enabled status");
    chk_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error answer without ready");
    chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && !hit |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past the access cycle");
endmodule : tlic_ctrl
`default_nettype wire

// ### tb/tlic_src_model.sv
// Purpose : peripheral request sources facing the controller
// Assumes : each flag is a level held until its service routine clears it
// Notes   : bit map 0 supply, 1 watchdog, 2 ext0, 3 conv, 4 tmr0, 5 ext1, 6 tmr1,
//           7 serial if, 8 rx, 9 tx, 10 t2 ovf, 11 t2 ext, 12 interval
`default_nettype none
module tlic_src_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [12:0] set_mask,
    input  wire logic [12:0] clr_mask,
    output logic      [12:0] req
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // held flags
    // ------------------------------------------------------------------
    logic [12:0] req_q;
    // set and clear in one cycle: clear wins, as a software clear would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 13'h0000;
        end else begin
            req_q <= (req_q | set_mask) & ~clr_mask;
        end
    end
    assign req = req_q;
endmodule : tlic_src_model
`default_nettype wire

// ### tb/two_level_interrupt_controller_tb.sv
// Purpose : self-checking bench for the controller over apb
// Assumes : pready comes in the access cycle; ack/reti are register writes
// Notes   : every wait is bounded; watchdog is high level by design choice
`default_nettype none
module two_level_interrupt_controller_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tlic_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] set_mask, clr_mask, req;
    tlic_vreq_t  vreq;
    int          fails, tests_run;
    int          pb [10] = '{0, 2, 3, 4, 5, 6, 7, 8, 10, 12};
    logic [15:0] vt [10] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                             16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
    tlic_ctrl u_tlic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_mon_request(req[0]), .watchdog_request(req[1]),
        .ext0_request(req[2]), .converter_request(req[3]), .timer0_overflow(req[4]),
        .ext1_request(req[5]), .timer1_overflow(req[6]), .serial_if_request(req[7]),
        .serial_rx_done(req[8]), .serial_tx_done(req[9]), .timer2_overflow(req[10]),
        .timer2_external_flag(req[11]), .interval_request(req[12]), .vreq(vreq), .irq(irq));
    tlic_src_model u_tlic_src_model (.pclk(pclk), .presetn(presetn), .set_mask(set_mask),
        .clr_mask(clr_mask), .req(req));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            $display("CHECK FAILED %0t bus answer missing", $time);
            close_out();
        end
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask : rdchk
    // one-cycle pulses into the source model
    task automatic pulse(input logic [12:0] s, input logic [12:0] c);
        @(posedge pclk);
        set_mask <= s;
        clr_mask <= c;
        @(posedge pclk);
        set_mask <= 13'h0000;
        clr_mask <= 13'h0000;
    endtask : pulse
    task automatic wait_vec(input logic [15:0] v);
        for (int n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (vreq.valid === 1'b1) break;
        end
        cmp({31'h0, vreq.valid}, 32'h1);
        cmp({16'h0, vreq.vector}, {16'h0, v});
        if (vreq.valid !== 1'b1) begin
            close_out();
        end
    endtask : wait_vec
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge pclk);
            cmp({31'h0, vreq.valid}, 32'h0);
        end
    endtask : quiet
    task automatic serve(input int b, input logic [15:0] v);
        wait_vec(v);
        apb(1'b1, TLIC_ADR_ACK, 32'h0);
        pulse(13'h0000, 13'h0001 << b);
        apb(1'b1, TLIC_ADR_RETI, 32'h0);
    endtask : serve
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, set_mask, clr_mask} = '0;
        fails     = 0;
        tests_run = 0;
        presetn   = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(TLIC_ADR_ENP, 32'h00);
        rdchk(TLIC_ADR_ENS, 32'hA0);
        rdchk(TLIC_ADR_PRP, 32'h00);
        rdchk(12'h010, 32'h0);
        cmp({31'h0, e}, 32'h1);
        $display("test reset values done");
        apb(1'b1, TLIC_ADR_IRQEN, 32'h8);
        apb(1'b1, TLIC_ADR_ENS, 32'h0F);
        rdchk(TLIC_ADR_ENS, 32'h07);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, TLIC_ADR_IRQEN, 32'h0);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        apb(1'b1, TLIC_ADR_IRQEN, 32'h8);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, TLIC_ADR_IRQCLR, 32'h8);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        rdchk(TLIC_ADR_IRQST, 32'h0);
        $display("test event interrupt done");
        apb(1'b1, TLIC_ADR_ENP, 32'h7F);
        pulse(13'h0004, 13'h0000);
        quiet(5);
        apb(1'b1, TLIC_ADR_ENP, 32'hFE);
        quiet(5);
        apb(1'b1, TLIC_ADR_ENP, 32'hFF);
        serve(2, 16'h0003);
        pulse(13'h0002, 13'h0000);
        serve(1, 16'h005B);
        $display("test gating done");
        pulse(13'h15FD, 13'h0000);
        for (int i = 0; i < 10; i++) begin
            wait_vec(vt[i]);
            apb(1'b1, TLIC_ADR_ACK, 32'h0);
            quiet(3);
            pulse(13'h0000, 13'h0001 << pb[i]);
            apb(1'b1, TLIC_ADR_RETI, 32'h0);
        end
        pulse(13'h0200, 13'h0000);
        serve(9, 16'h0023);
        pulse(13'h0800, 13'h0000);
        serve(11, 16'h002B);
        $display("test polling order done");
        apb(1'b1, TLIC_ADR_PRP, 32'h08);
        apb(1'b1, TLIC_ADR_IRQEN, 32'h2);
        pulse(13'h0044, 13'h0000);
        serve(6, 16'h001B);
        serve(2, 16'h0003);
        pulse(13'h0004, 13'h0000);
        wait_vec(16'h0003);
        apb(1'b1, TLIC_ADR_ACK, 32'h0);
        pulse(13'h0040, 13'h0000);
        wait_vec(16'h001B);
        rdchk(TLIC_ADR_STAT, 32'h00000DB1);
        apb(1'b1, TLIC_ADR_ACK, 32'h0);
        rdchk(TLIC_ADR_STAT, 32'h00000003);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, TLIC_ADR_IRQCLR, 32'h2);
        pulse(13'h0000, 13'h0040);
        apb(1'b1, TLIC_ADR_RETI, 32'h0);
        pulse(13'h0000, 13'h0004);
        apb(1'b1, TLIC_ADR_RETI, 32'h0);
        rdchk(TLIC_ADR_STAT, 32'h0);
        $display("test preemption done");
        apb(1'b1, TLIC_ADR_PRP, 32'h00);
        apb(1'b1, TLIC_ADR_ENS, 32'h47);
        pulse(13'h1001, 13'h0000);
        serve(12, 16'h0053);
        serve(0, 16'h0043);
        apb(1'b1, TLIC_ADR_ENS, 32'h27);
        pulse(13'h0003, 13'h0000);
        serve(0, 16'h0043);
        serve(1, 16'h005B);
        $display("test secondary levels done");
        close_out();
    end
endmodule : two_level_interrupt_controller_tb
`default_nettype wire
